// >>> include/adcsc_pkg.sv
package adcsc_pkg;
    localparam logic [7:0] ADCSC_ADDR_SYS = 8'h09;
    localparam logic [7:0] ADCSC_ADDR_RSVD = 8'h0a;
    localparam logic [7:0] ADCSC_ADDR_OFCL = 8'h0b;
    localparam logic [7:0] ADCSC_SYS_RESET = 8'h10;
    localparam logic [7:0] ADCSC_RSVD_VALUE = 8'h00;
    localparam logic [7:0] ADCSC_OFCL_RESET = 8'h00;
    localparam logic [7:0] ADCSC_UNMAPPED = 8'h00;
    localparam int ADCSC_MON_HI = 7;
    localparam int ADCSC_MON_LO = 5;
    localparam int ADCSC_CAL_HI = 4;
    localparam int ADCSC_CAL_LO = 3;
    localparam int ADCSC_TMO_BIT = 2;
    localparam int ADCSC_CRC_BIT = 1;
    localparam int ADCSC_STAT_BIT = 0;
    localparam logic [2:0] ADCSC_MON_OFF = 3'h0;
    localparam logic [2:0] ADCSC_MON_SHORT = 3'h1;
    localparam logic [2:0] ADCSC_MON_TEMP = 3'h2;
    localparam logic [2:0] ADCSC_MON_ANALOG_SUPPLY_POSITIVE = 3'h3;
    localparam logic [2:0] ADCSC_MON_DIGITAL_SUPPLY = 3'h4;
    localparam logic [2:0] ADCSC_MON_BO02 = 3'h5;
    localparam logic [2:0] ADCSC_MON_BO1 = 3'h6;
    localparam logic [2:0] ADCSC_MON_BO10 = 3'h7;
    localparam logic [1:0] ADCSC_AMP_EN_ON = 2'h1;
    localparam logic [2:0] ADCSC_GAIN_ONE = 3'h0;
    localparam logic [2:0] ADCSC_GAIN_FOUR = 3'h2;
    localparam logic [4:0] ADCSC_SAMP_1 = 5'h01;
    localparam logic [4:0] ADCSC_SAMP_4 = 5'h04;
    localparam logic [4:0] ADCSC_SAMP_8 = 5'h08;
    localparam logic [4:0] ADCSC_SAMP_16 = 5'h10;
    localparam logic [1:0] ADCSC_BO_OFF = 2'h0;
    localparam logic [1:0] ADCSC_BO_0P2 = 2'h1;
    localparam logic [1:0] ADCSC_BO_1 = 2'h2;
    localparam logic [1:0] ADCSC_BO_10 = 2'h3;
    typedef enum logic [1:0] {
        ADCSC_SUP_NONE,
        ADCSC_SUP_ANALOG,
        ADCSC_SUP_DIGITAL
    } adcsc_sup_t;
endpackage

// >>> verilog/adcsc_decode.sv
`timescale 1ns/10ps
// decodes monitor and sample fields into analog front-end controls
module adcsc_decode
    import adcsc_pkg::*;
(
    // fields
    input wire logic [2:0] monitor_select,
    input wire logic [1:0] cal_field,
    input wire logic [2:0] user_gain,
    // decoded controls
    output logic mid_short,
    output logic temp_sense,
    output adcsc_sup_t supply_sel,
    output logic [1:0] burnout_level,
    output logic mux_open,
    output logic [2:0] eff_gain,
    output logic [4:0] cal_samples
);
    // monitor mode decode
    always_comb
    begin
        mid_short = 1'b0;
        temp_sense = 1'b0;
        supply_sel = ADCSC_SUP_NONE;
        burnout_level = ADCSC_BO_OFF;
        case (monitor_select)
            ADCSC_MON_SHORT: mid_short = 1'b1;
            ADCSC_MON_TEMP: temp_sense = 1'b1;
            ADCSC_MON_ANALOG_SUPPLY_POSITIVE: supply_sel = ADCSC_SUP_ANALOG;
            ADCSC_MON_DIGITAL_SUPPLY: supply_sel = ADCSC_SUP_DIGITAL;
            ADCSC_MON_BO02: burnout_level = ADCSC_BO_0P2;
            ADCSC_MON_BO1: burnout_level = ADCSC_BO_1;
            ADCSC_MON_BO10: burnout_level = ADCSC_BO_10;
            default: ; // off: nothing enabled
        endcase
        // burn-out modes still need the inputs, so switches stay under mux
        mux_open = mid_short | temp_sense |
            (supply_sel != ADCSC_SUP_NONE);
        eff_gain = (supply_sel != ADCSC_SUP_NONE) ? ADCSC_GAIN_ONE
            : user_gain;
        case (cal_field)
            2'h0: cal_samples = ADCSC_SAMP_1;
            2'h1: cal_samples = ADCSC_SAMP_4;
            2'h2: cal_samples = ADCSC_SAMP_8;
            default: cal_samples = ADCSC_SAMP_16;
        endcase
    end
endmodule

// >>> verilog/adcsc_regs.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
// system control byte, reserved byte and offset low byte
module adcsc_regs
    import adcsc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // amplifier settings from the gain register
    input wire logic [2:0] user_gain,
    input wire logic [1:0] amplifier_enable,
    // front-end controls
    output logic mid_short,
    output logic temp_sense,
    output logic supply_analog,
    output logic supply_digital,
    output logic [1:0] burnout_level,
    output logic mux_open,
    output logic [2:0] eff_gain,
    output logic [4:0] cal_samples,
    output logic timeout_enable,
    output logic crc_enable,
    output logic status_byte_prepend,
    output logic [7:0] offset_calibration_low,
    // host misuse flags
    output logic temp_setup_bad,
    output logic reserved_write_nonzero
);
    typedef struct packed {
        logic [7:0] system_control;
        logic [7:0] ofcl;
        logic [7:0] rdata;
        logic mid_short;
        logic temp_sense;
        logic sup_a;
        logic sup_d;
        logic [1:0] bo;
        logic mux_open;
        logic [2:0] gain;
        logic [4:0] samples;
        logic temp_bad;
        logic rsvd_bad;
    } adcsc_state_t;

    adcsc_state_t st_q;
    adcsc_state_t st_d;
    logic dec_short;
    logic dec_temp;
    adcsc_sup_t dec_sup;
    logic [1:0] dec_bo;
    logic dec_open;
    logic [2:0] dec_gain;
    logic [4:0] dec_samples;
    logic [7:0] sys_nxt;

    // next control byte, worked out apart from st_d so the decoder
    // output never loops back into the process that reads it
    assign sys_nxt = (reg_write && reg_addr == ADCSC_ADDR_SYS) ? reg_wdata
        : st_q.system_control;

    // decode runs on the next register value so controls follow writes
    // in the same edge as the stored byte
    adcsc_decode u_decode (
        .monitor_select(sys_nxt[ADCSC_MON_HI:ADCSC_MON_LO]),
        .cal_field(sys_nxt[ADCSC_CAL_HI:ADCSC_CAL_LO]),
        .user_gain(user_gain),
        .mid_short(dec_short),
        .temp_sense(dec_temp),
        .supply_sel(dec_sup),
        .burnout_level(dec_bo),
        .mux_open(dec_open),
        .eff_gain(dec_gain),
        .cal_samples(dec_samples)
    );

    // next-state logic for writes, reads and decoded outputs
    always_comb
    begin
        st_d = st_q;
        st_d.rdata = ADCSC_UNMAPPED;
        if (reg_write)
        begin
            if (reg_addr == ADCSC_ADDR_SYS)
            begin
                st_d.system_control = reg_wdata;
            end
            else if (reg_addr == ADCSC_ADDR_OFCL)
            begin
                st_d.ofcl = reg_wdata;
            end
            else if (reg_addr == ADCSC_ADDR_RSVD)
            begin
                // value is dropped; only flag a nonzero write
                st_d.rsvd_bad = st_q.rsvd_bad | (reg_wdata != 8'h00);
            end
        end
        if (reg_read)
        begin
            if (reg_addr == ADCSC_ADDR_SYS)
            begin
                st_d.rdata = st_q.system_control;
            end
            else if (reg_addr == ADCSC_ADDR_RSVD)
            begin
                st_d.rdata = ADCSC_RSVD_VALUE;
            end
            else if (reg_addr == ADCSC_ADDR_OFCL)
            begin
                st_d.rdata = st_q.ofcl;
            end
        end
        st_d.mid_short = dec_short;
        st_d.temp_sense = dec_temp;
        st_d.sup_a = (dec_sup == ADCSC_SUP_ANALOG);
        st_d.sup_d = (dec_sup == ADCSC_SUP_DIGITAL);
        st_d.bo = dec_bo;
        st_d.mux_open = dec_open;
        st_d.gain = dec_gain;
        st_d.samples = dec_samples;
        // live check of the host's duty in temperature mode
        st_d.temp_bad = dec_temp && (amplifier_enable != ADCSC_AMP_EN_ON
            || user_gain > ADCSC_GAIN_FOUR);
    end

    // state register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
            st_q.system_control <= ADCSC_SYS_RESET;
            st_q.ofcl <= ADCSC_OFCL_RESET;
            st_q.samples <= ADCSC_SAMP_8;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // outputs come straight from the state flops
    assign reg_rdata = st_q.rdata;
    assign mid_short = st_q.mid_short;
    assign temp_sense = st_q.temp_sense;
    assign supply_analog = st_q.sup_a;
    assign supply_digital = st_q.sup_d;
    assign burnout_level = st_q.bo;
    assign mux_open = st_q.mux_open;
    assign eff_gain = st_q.gain;
    assign cal_samples = st_q.samples;
    assign timeout_enable = st_q.system_control[ADCSC_TMO_BIT];
    assign crc_enable = st_q.system_control[ADCSC_CRC_BIT];
    assign status_byte_prepend = st_q.system_control[ADCSC_STAT_BIT];
    assign offset_calibration_low = st_q.ofcl;
    assign temp_setup_bad = st_q.temp_bad;
    assign reserved_write_nonzero = st_q.rsvd_bad;
endmodule

// >>> testbench/adcsc_props.sv
`timescale 1ns/10ps
// port-level checks of the control byte decode and the read path
module adcsc_props
    import adcsc_pkg::*;
(
    // clock, reset, register port
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    // decoded controls
    input wire logic mid_short,
    input wire logic temp_sense,
    input wire logic supply_analog,
    input wire logic supply_digital,
    input wire logic [1:0] burnout_level,
    input wire logic mux_open,
    input wire logic [2:0] eff_gain,
    input wire logic [4:0] cal_samples,
    input wire logic timeout_enable,
    input wire logic crc_enable,
    input wire logic status_byte_prepend,
    input wire logic [7:0] offset_calibration_low
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // write strobes of the two writable bytes
    logic w9, wb;
    assign w9 = reg_write && reg_addr == ADCSC_ADDR_SYS;
    assign wb = reg_write && reg_addr == ADCSC_ADDR_OFCL;
    chk_mid_short: assert property (w9 |=> mid_short ==
        ($past(reg_wdata[7:5]) == 3'h1)) else $error("mid short wrong");
    chk_temp_mode: assert property (w9 |=> temp_sense ==
        ($past(reg_wdata[7:5]) == 3'h2)) else $error("temp mode wrong");
    chk_supply_mode: assert property (w9 |=> {supply_analog,
        supply_digital} == {$past(reg_wdata[7:5]) == 3'h3,
        $past(reg_wdata[7:5]) == 3'h4}) else $error("supply mode wrong");
    chk_burnout_level: assert property (w9 && reg_wdata[7]
        |=> burnout_level == $past(reg_wdata[6:5]))
        else $error("burnout level wrong");
    chk_mux_open: assert property (mux_open == (mid_short |
        temp_sense | supply_analog | supply_digital))
        else $error("mux state wrong");
    chk_gain_forced: assert property ((supply_analog ||
        supply_digital) |-> eff_gain == 3'h0) else $error("gain not one");
    chk_cal_samples: assert property (w9 |=> cal_samples ==
        (($past(reg_wdata[4:3]) == 2'h0) ? 5'h01
        : 5'h02 << $past(reg_wdata[4:3])))
        else $error("sample count wrong");
    chk_flag_bits: assert property (w9 |=>
        {timeout_enable, crc_enable, status_byte_prepend}
        == $past(reg_wdata[2:0])) else $error("flag bits wrong");
    chk_rsvd_read: assert property (reg_read && reg_addr ==
        ADCSC_ADDR_RSVD |=> reg_rdata == 8'h00) else $error("rsvd nonzero");
    chk_ofcl_write: assert property (wb |=> offset_calibration_low
        == $past(reg_wdata)) else $error("offset byte wrong");
endmodule
bind adcsc_regs adcsc_props adcsc_props_i (.*);

// >>> testbench/adcsc_host.sv
`timescale 1ns/10ps
// host side: register port master plus the amplifier settings
module adcsc_host
(
    input wire logic clk,
    output logic [7:0] reg_addr = 8'h00,
    output logic [7:0] reg_wdata = 8'h00,
    output logic reg_write = 1'b0,
    output logic reg_read = 1'b0,
    input wire logic [7:0] reg_rdata,
    output logic [2:0] user_gain = 3'h0,
    output logic [1:0] amplifier_enable = 2'h1
);
    // gain codes above x4 are never sent, the sensor would clip
    task setg(input logic [2:0] g);
        @(posedge clk);
        user_gain <= (g > 3'h2) ? 3'h2 : g;
    endtask
    // one-cycle write; the reserved byte only ever gets zero
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= (a == 8'h0a) ? 8'h00 : d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    // data is only valid in the cycle after the strobe
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
endmodule

// >>> testbench/tb_adcsc_regs.sv
`timescale 1ns/10ps
module tb_adcsc_regs
    import adcsc_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0;
    logic [7:0] a, wd, wdt, rdt, ofc;
    logic [2:0] ug, eg;
    logic [1:0] ae, bo;
    logic wr, rd, ms, ts, sa, sd, mo, te, ce, sb, tb, rw;
    logic [4:0] cs;
    logic [7:0] v;
    logic [17:0] ctl;
    logic [31:0] lf = 32'haaa7;
    int err_total = 0, n_checks = 0;
    always #2.5 clk = ~clk;
    adcsc_host adcsc_host_i (.clk(clk), .reg_addr(a), .reg_wdata(wd),
        .reg_write(wr), .reg_read(rd), .reg_rdata(rdt), .user_gain(ug),
        .amplifier_enable(ae));
    adcsc_regs adcsc_regs_i (.clk(clk), .rst_n(rst_n), .reg_addr(a),
        .reg_wdata(wd), .reg_write(wr), .reg_read(rd), .reg_rdata(rdt),
        .user_gain(ug), .amplifier_enable(ae), .mid_short(ms),
        .temp_sense(ts), .supply_analog(sa), .supply_digital(sd),
        .burnout_level(bo), .mux_open(mo), .eff_gain(eg), .cal_samples(cs),
        .timeout_enable(te), .crc_enable(ce), .status_byte_prepend(sb),
        .offset_calibration_low(ofc), .temp_setup_bad(tb),
        .reserved_write_nonzero(rw));
    // all decoded controls in the order that exp_c returns them
    assign ctl = {ms, ts, sa, sd, bo, mo, eg, cs, te, ce, sb};
    // galois-free shift register keeps the run repeatable
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // expected controls for a control byte and gain code
    function automatic logic [17:0] exp_c(input logic [7:0] x,
        input logic [2:0] g);
        logic [2:0] m;
        m = x[7:5];
        return {m == 3'h1, m == 3'h2, m == 3'h3, m == 3'h4,
            m[2] ? m[1:0] : 2'h0, m != 3'h0 && m < 3'h5,
            (m == 3'h3 || m == 3'h4) ? 3'h0 : g,
            (x[4:3] == 2'h0) ? 5'h01 : 5'h02 << x[4:3], x[2:0]};
    endfunction
    task chk(input logic [17:0] got, input logic [17:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task give_verdict;
        $display("checks=%0d mismatches=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        err_total++;
        give_verdict;
    end
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        // values straight out of reset
        adcsc_host_i.rd(ADCSC_ADDR_SYS, v);
        chk(v, 8'h10);
        chk(ctl, exp_c(8'h10, 3'h0));
        adcsc_host_i.rd(ADCSC_ADDR_OFCL, v);
        chk(v, 8'h00);
        $display("reset test done");
        // every monitor mode, random low bits and gain, then readback
        for (int i = 0; i < 32; i++)
        begin
            lf = nxt(lf);
            adcsc_host_i.setg({1'b0, lf[9:8] % 2'h3});
            wdt = {i[2:0], lf[4:0]};
            adcsc_host_i.wr(ADCSC_ADDR_SYS, wdt);
            #1 chk(ctl, exp_c(wdt, ug));
            chk(tb, 1'b0);
            adcsc_host_i.rd(ADCSC_ADDR_SYS, v);
            chk(v, wdt);
        end
        $display("mode test done");
        // offset byte, reserved byte and an unmapped place
        for (int i = 0; i < 8; i++)
        begin
            lf = nxt(lf);
            adcsc_host_i.wr(ADCSC_ADDR_OFCL, lf[7:0]);
            #1 chk(ofc, lf[7:0]);
            adcsc_host_i.rd(ADCSC_ADDR_OFCL, v);
            chk(v, lf[7:0]);
            adcsc_host_i.wr(ADCSC_ADDR_RSVD, 8'h00);
            #1 chk(rw, 1'b0);
            adcsc_host_i.rd(ADCSC_ADDR_RSVD, v);
            chk(v, 8'h00);
            adcsc_host_i.rd(8'h20 + lf[15:12], v);
            chk(v, 8'h00);
        end
        $display("byte test done");
        give_verdict;
    end
endmodule
